// >>> bss_pkg.sv
// constants, types and register map of the brake and slip supervisor
package bss_pkg;
	// register indices on the plain register port
	localparam int BSS_AW = 3;
	localparam logic [2:0] BSS_REG_CTRL = 3'h0;
	localparam logic [2:0] BSS_REG_DLY_A = 3'h1;
	localparam logic [2:0] BSS_REG_DLY_B = 3'h2;
	localparam logic [2:0] BSS_REG_SUP = 3'h3;
	localparam logic [2:0] BSS_REG_STAT = 3'h4;
	localparam logic [2:0] BSS_REG_MASK = 3'h5;
	localparam logic [2:0] BSS_REG_INFO = 3'h6;
	// control register bit positions
	localparam int BSS_C_BRAKE = 0;
	localparam int BSS_C_CUTOFF = 1;
	localparam int BSS_C_SUP = 2;
	localparam int BSS_C_SRC = 3;
	localparam int BSS_C_INV = 4;
	localparam int BSS_C_ACT = 5;
	localparam int BSS_C_PWR = 8;
	localparam int BSS_C_CLR = 9;
	// status and mask bit positions
	localparam int BSS_S_SLIP = 0;
	localparam int BSS_S_READY = 1;
	localparam int BSS_S_ENGAGED = 2;
	localparam int BSS_S_START = 3;
	localparam int BSS_NSTAT = 4;
	// field positions in the shared words
	localparam int BSS_HI = 16;
	localparam int BSS_F_STEPS = 8;
	localparam int BSS_F_DIFF = 8;
	// sequencer states
	typedef enum logic [2:0] {
		BSS_OFF,
		BSS_WAIT_REL,
		BSS_WAIT_RDY,
		BSS_READY,
		BSS_WAIT_ENG,
		BSS_WAIT_OFF,
		BSS_HOLD
	} bss_seq_type;
	// slip error actions; the fourth code acts as ignore
	typedef enum logic [1:0] {
		BSS_ACT_ALARM,
		BSS_ACT_CORRECT,
		BSS_ACT_IGNORE
	} bss_act_type;
	// software settings
	typedef struct packed {
		logic brake_en;
		logic cutoff_en;
		logic sup_en;
		logic src_rev;
		logic rev_inv;
		bss_act_type act;
		logic power_req;
		logic [15:0] d_rel;
		logic [15:0] d_rdy;
		logic [15:0] d_eng;
		logic [15:0] d_off;
		logic [7:0] thr;
		logic [15:0] rev_steps;
	} bss_cfg_type;
	localparam bss_cfg_type BSS_CFG_RST = '{
		brake_en: 1'b0, cutoff_en: 1'b0, sup_en: 1'b0, src_rev: 1'b0,
		rev_inv: 1'b0, act: BSS_ACT_ALARM, power_req: 1'b0,
		d_rel: 16'h012c, d_rdy: 16'h01f4, d_eng: 16'h012c,
		d_off: 16'h0190, thr: 8'h08, rev_steps: 16'h00c8};
	// whole state of the supervisor
	typedef struct packed {
		bss_cfg_type cfg;
		bss_seq_type seq;
		logic [15:0] cnt;
		logic pend;
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [2:0] pin_p;
		logic signed [23:0] diff;
		logic over;
		logic [3:0] stat;
		logic [3:0] mask;
		logic alarm;
		logic corr;
		logic start;
		logic [31:0] rdata;
	} bss_state_type;
endpackage

// >>> bss_supervisor.sv
// brake sequencing and missed-step supervision for one motor axis
// Operation
// RULE1: brake sequence runs only when brake enabled
// RULE2: power on, wait delay, release brake
// RULE3: brake released, wait delay, axis ready
// RULE4: motion commands deferred until axis ready
// RULE5: motor stopped, wait delay, engage brake
// RULE6: brake engaged, wait delay, remove power
// RULE7: four delays are 16-bit millisecond counts
// RULE8: cutoff setting ends sequence with power off
// RULE9: missed-step supervision only when enabled
// RULE10: feedback source encoder or revolution sensor
// RULE11: missed-step threshold is 8-bit count
// RULE12: missed above threshold sets slip flag
// RULE13: alarm action enters alarm state
// RULE14: correct action starts loss correction
// RULE15: ignore action does nothing beyond flag
// RULE16: revolution sensor polarity set by invert
// RULE17: error action is one encoded field
// RULE18: slip flag sticky until cleared
`timescale 1ns/1ns
`default_nettype none
module bss_supervisor
	import bss_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tick_ms_in,
	input wire logic [BSS_AW-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic move_req_in,
	input wire logic motor_stopped_in,
	input wire logic step_in,
	input wire logic step_dir_in,
	input wire logic enc_a_in,
	input wire logic enc_b_in,
	input wire logic rev_in,
	output logic motor_power_out,
	output logic brake_release_out,
	output logic brake_oe_out,
	output logic axis_ready_out,
	output logic move_start_out,
	output logic alarm_out,
	output logic correct_start_out,
	output logic irq_out
);
	bss_state_type q;
	bss_state_type n;
	logic [15:0] dly;
	logic done;
	logic [3:0] set;
	logic [3:0] clr;
	logic enc_mv;
	logic enc_up;
	logic rev_act;
	logic rev_prev;
	logic rev_edge;
	logic signed [23:0] delta;
	logic [23:0] missed;
	logic det;

	// delay belonging to each waiting state
	function automatic logic [15:0] sel_dly(bss_seq_type s, bss_cfg_type c);
		logic [15:0] r;
		r = 16'h0000;
		unique case (s)
			BSS_WAIT_REL: r = c.d_rel;
			BSS_WAIT_RDY: r = c.d_rdy;
			BSS_WAIT_ENG: r = c.d_eng;
			BSS_WAIT_OFF: r = c.d_off;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	// readback of every mapped word; unmapped indices read zero
	function automatic logic [31:0] rd_mux(logic [2:0] a, bss_state_type s);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			BSS_REG_CTRL:
			begin
				r[BSS_C_BRAKE] = s.cfg.brake_en;
				r[BSS_C_CUTOFF] = s.cfg.cutoff_en;
				r[BSS_C_SUP] = s.cfg.sup_en;
				r[BSS_C_SRC] = s.cfg.src_rev;
				r[BSS_C_INV] = s.cfg.rev_inv;
				r[BSS_C_ACT+:2] = s.cfg.act;
				r[BSS_C_PWR] = s.cfg.power_req;
			end
			BSS_REG_DLY_A: r = {s.cfg.d_rdy, s.cfg.d_rel};
			BSS_REG_DLY_B: r = {s.cfg.d_off, s.cfg.d_eng};
			BSS_REG_SUP: r = {8'h00, s.cfg.rev_steps, s.cfg.thr};
			BSS_REG_STAT: r = {28'h000_0000, s.stat};
			BSS_REG_MASK: r = {28'h000_0000, s.mask};
			BSS_REG_INFO: r = {s.diff, 5'h00, s.seq};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// feedback decoding from the synchronised pins
	always_comb
	begin
		enc_mv = (q.pin_s2[2] ^ q.pin_p[2]) ^ (q.pin_s2[1] ^ q.pin_p[1]);
		enc_up = q.pin_s2[2] ^ q.pin_p[1];
		rev_act = q.cfg.rev_inv ? q.pin_s2[0] : ~q.pin_s2[0]; // RULE16
		rev_prev = q.cfg.rev_inv ? q.pin_p[0] : ~q.pin_p[0];
		rev_edge = rev_act & ~rev_prev;
		// commanded steps add, measured steps take away
		delta = 24'sh000000;
		if (step_in)
		begin
			delta = step_dir_in ? 24'sh000001 : -24'sh000001;
		end
		if (!q.cfg.src_rev && enc_mv) // RULE10
		begin
			delta = delta + (enc_up ? -24'sh000001 : 24'sh000001);
		end
		// a whole revolution settles a full turn of steps at once
		if (q.cfg.src_rev && rev_edge) // RULE10
		begin
			if (step_dir_in)
			begin
				delta = delta - $signed({8'h00, q.cfg.rev_steps});
			end
			else
			begin
				delta = delta + $signed({8'h00, q.cfg.rev_steps});
			end
		end
		missed = q.diff[23] ? 24'(-q.diff) : 24'(q.diff);
	end

	// next-state logic for the whole supervisor
	always_comb
	begin
		n = q;
		set = 4'h0;
		clr = 4'h0;
		n.corr = 1'b0;
		n.start = 1'b0;
		// synchronisers; first stage feeds only the second
		n.pin_s1 = {enc_a_in, enc_b_in, rev_in};
		n.pin_s2 = q.pin_s1;
		n.pin_p = q.pin_s2;
		// millisecond counter of the current waiting state
		dly = sel_dly(q.seq, q.cfg); // RULE7
		done = q.cnt >= dly;
		if (tick_ms_in && !done)
		begin
			n.cnt = q.cnt + 16'h0001;
		end
		// power and brake sequence
		unique case (q.seq)
			BSS_OFF:
			begin
				if (q.cfg.power_req)
				begin
					// with no brake, power and readiness come together
					n.seq = q.cfg.brake_en ? BSS_WAIT_REL : BSS_READY; // RULE1
				end
			end
			BSS_WAIT_REL:
			begin
				if (done)
				begin
					n.seq = BSS_WAIT_RDY; // RULE2
				end
			end
			BSS_WAIT_RDY:
			begin
				if (done)
				begin
					n.seq = BSS_READY; // RULE3
				end
			end
			BSS_READY:
			begin
				if (!q.cfg.power_req && motor_stopped_in)
				begin
					n.seq = q.cfg.brake_en ? BSS_WAIT_ENG : BSS_OFF; // RULE1
				end
			end
			BSS_WAIT_ENG:
			begin
				if (done)
				begin
					n.seq = BSS_WAIT_OFF; // RULE5
				end
			end
			BSS_WAIT_OFF:
			begin
				if (done)
				begin
					set[BSS_S_ENGAGED] = 1'b1;
					n.seq = q.cfg.cutoff_en ? BSS_OFF : BSS_HOLD; // RULE6 RULE8
				end
			end
			BSS_HOLD:
			begin
				// power kept, brake holding; a new request releases again
				if (q.cfg.power_req)
				begin
					n.seq = BSS_WAIT_REL;
				end
			end
			default: n.seq = BSS_OFF;
		endcase
		if (n.seq != q.seq)
		begin
			n.cnt = 16'h0000;
		end
		if (n.seq == BSS_READY && q.seq != BSS_READY)
		begin
			set[BSS_S_READY] = 1'b1;
		end
		// deferred motion command; a new request in the start cycle stays pending
		if (q.pend && q.seq == BSS_READY)
		begin
			n.start = 1'b1; // RULE4
			set[BSS_S_START] = 1'b1;
		end
		n.pend = (q.pend && !n.start) || move_req_in; // RULE4
		// missed-step supervision
		n.diff = q.diff + delta;
		n.over = q.cfg.sup_en && (missed > {16'h0000, q.cfg.thr}); // RULE9 RULE11
		det = n.over && !q.over;
		if (n.over)
		begin
			set[BSS_S_SLIP] = 1'b1; // RULE12
		end
		// one action only, chosen by the encoded field
		if (det)
		begin
			unique case (q.cfg.act) // RULE17
				BSS_ACT_ALARM: n.alarm = 1'b1; // RULE13
				BSS_ACT_CORRECT: n.corr = 1'b1; // RULE14
				default: n.corr = 1'b0; // RULE15
			endcase
		end
		// register writes
		if (wr_in)
		begin
			unique case (addr_in)
				BSS_REG_CTRL:
				begin
					n.cfg.brake_en = wdata_in[BSS_C_BRAKE];
					n.cfg.cutoff_en = wdata_in[BSS_C_CUTOFF];
					n.cfg.sup_en = wdata_in[BSS_C_SUP];
					n.cfg.src_rev = wdata_in[BSS_C_SRC];
					n.cfg.rev_inv = wdata_in[BSS_C_INV];
					n.cfg.act = bss_act_type'(wdata_in[BSS_C_ACT+:2]);
					n.cfg.power_req = wdata_in[BSS_C_PWR];
					if (wdata_in[BSS_C_CLR])
					begin
						// restart the count after the axis is re-referenced
						n.diff = 24'sh000000;
					end
				end
				BSS_REG_DLY_A:
				begin
					n.cfg.d_rel = wdata_in[15:0]; // RULE7
					n.cfg.d_rdy = wdata_in[BSS_HI+:16];
				end
				BSS_REG_DLY_B:
				begin
					n.cfg.d_eng = wdata_in[15:0];
					n.cfg.d_off = wdata_in[BSS_HI+:16];
				end
				BSS_REG_SUP:
				begin
					n.cfg.thr = wdata_in[7:0]; // RULE11
					n.cfg.rev_steps = wdata_in[BSS_F_STEPS+:16];
				end
				BSS_REG_MASK: n.mask = wdata_in[BSS_NSTAT-1:0];
				default: n.mask = q.mask;
			endcase
		end
		// reading status clears it, but a new event in that cycle stays
		if (rd_in && addr_in == BSS_REG_STAT)
		begin
			clr = 4'hf;
			n.alarm = det && q.cfg.act == BSS_ACT_ALARM; // set wins
		end
		n.stat = (q.stat & ~clr) | set; // RULE18
		n.rdata = rd_in ? rd_mux(addr_in, q) : 32'h0000_0000;
	end

	// one register for all state; synchronous reset
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			q <= '0;
			q.cfg <= BSS_CFG_RST;
		end
		else
		begin
			q <= n;
		end
	end

	// outputs decoded from registered state
	assign motor_power_out = q.seq != BSS_OFF;
	assign brake_release_out = q.cfg.brake_en &&
		(q.seq == BSS_WAIT_RDY || q.seq == BSS_READY ||
		q.seq == BSS_WAIT_ENG); // RULE1
	assign brake_oe_out = q.cfg.brake_en; // RULE1
	assign axis_ready_out = q.seq == BSS_READY;
	assign move_start_out = q.start;
	assign alarm_out = q.alarm;
	assign correct_start_out = q.corr;
	assign irq_out = |(q.stat & q.mask);
	assign rdata_out = q.rdata;

	// checks on the sequencer and supervision
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_nobrake_direct;
		$rose(motor_power_out) && !q.cfg.brake_en |-> axis_ready_out;
	endproperty
	a_nobrake_direct: assert property (p_nobrake_direct) // RULE1
		else $error("power without brake did not give readiness");
	property p_release_delay;
		$rose(brake_release_out) |->
			$past(q.seq) == BSS_WAIT_REL && $past(q.cnt) >= q.cfg.d_rel;
	endproperty
	a_release_delay: assert property (p_release_delay) // RULE2
		else $error("brake released before its delay");
	property p_ready_delay;
		$rose(axis_ready_out) && q.cfg.brake_en |->
			$past(q.cnt) >= q.cfg.d_rdy && $past(brake_release_out);
	endproperty
	a_ready_delay: assert property (p_ready_delay) // RULE3
		else $error("axis ready before its delay");
	property p_start_ready;
		move_start_out |-> axis_ready_out && $past(q.pend);
	endproperty
	a_start_ready: assert property (p_start_ready) // RULE4
		else $error("motion started while axis not ready");
	property p_engage_delay;
		$fell(brake_release_out) && q.seq == BSS_WAIT_OFF |->
			$past(q.cnt) >= q.cfg.d_eng;
	endproperty
	a_engage_delay: assert property (p_engage_delay) // RULE5
		else $error("brake engaged before its delay");
	property p_off_delay;
		q.seq == BSS_WAIT_OFF && q.cnt < q.cfg.d_off |=> motor_power_out;
	endproperty
	a_off_delay: assert property (p_off_delay) // RULE6
		else $error("power removed before its delay");
	property p_cutoff;
		q.seq == BSS_WAIT_OFF && q.cnt >= q.cfg.d_off && q.cfg.cutoff_en
			|=> !motor_power_out;
	endproperty
	a_cutoff: assert property (p_cutoff) // RULE8
		else $error("cutoff did not remove power");
	// compare and flag share one edge, so the flag shows the next cycle
	property p_slip_set;
		q.cfg.sup_en && missed > {16'h0000, q.cfg.thr} |=>
			q.stat[BSS_S_SLIP];
	endproperty
	a_slip_set: assert property (p_slip_set) // RULE12
		else $error("slip flag not set above threshold");
	property p_slip_sticky;
		q.stat[BSS_S_SLIP] && !(rd_in && addr_in == BSS_REG_STAT) |=>
			q.stat[BSS_S_SLIP];
	endproperty
	a_slip_sticky: assert property (p_slip_sticky) // RULE18
		else $error("slip flag cleared without a status read");
	property p_alarm;
		det && q.cfg.act == BSS_ACT_ALARM |=> alarm_out;
	endproperty
	a_alarm: assert property (p_alarm) // RULE13
		else $error("alarm action did not raise alarm");
	property p_ignore;
		det && q.cfg.act == BSS_ACT_IGNORE |=> !correct_start_out && !alarm_out;
	endproperty
	a_ignore: assert property (p_ignore) // RULE15
		else $error("ignore action caused an action");

	property p_cov_start;
		move_req_in && !axis_ready_out ##[1:300] move_start_out;
	endproperty
	c_cov_start: cover property (p_cov_start);
	c_cov_cutoff: cover property ($fell(motor_power_out) && q.cfg.brake_en);
	c_cov_corr: cover property (correct_start_out);
endmodule
`default_nettype wire

// >>> bss_axis_model.sv
// motor driver and feedback model for the supervisor bench
`timescale 1ns/1ns
`default_nettype none
module bss_axis_model
(
	input wire logic clk_in,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic drop_in,
	input wire logic inv_in,
	input wire logic turn_in,
	output logic enc_a_out,
	output logic enc_b_out,
	output logic rev_out,
	output logic stopped_out
);
	logic [1:0] ph_q = 2'h0;
	logic [3:0] idle_q = 4'h0;
	// one quadrature edge a step; drop_in models lost feedback
	always @(posedge clk_in)
	begin
		if (step_in && !drop_in)
			ph_q <= dir_in ? ph_q + 2'h1 : ph_q - 2'h1;
		idle_q <= step_in ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
	end
	// channel a leads b while stepping forward
	assign enc_a_out = ph_q[1] ^ ph_q[0];
	assign enc_b_out = ph_q[1];
	// sensor at its active level only while the bench turns it
	assign rev_out = turn_in ~^ inv_in;
	// stopped only after a quiet spell, not at once
	assign stopped_out = idle_q == 4'hf;
endmodule
`default_nettype wire

// >>> bss_supervisor_tb_top.sv
// self-checking bench of the brake and slip supervisor
`timescale 1ns/1ns
`default_nettype none
module bss_supervisor_tb_top
	import bss_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic tick = 1'b0, wr = 1'b0, rd = 1'b0, mreq = 1'b0, step = 1'b0;
	logic dir = 1'b1, drop = 1'b1, inv = 1'b0, turn = 1'b0;
	logic [BSS_AW-1:0] addr = 3'h0;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'hea2d, rv;
	logic stopped, enc_a, enc_b, rev, pwr, rel, oe, rdy, mst, alm, cst, irq;
	int n_fail = 0, num_checks = 0, n_st = 0, n_co = 0, cyc = 0, n, t;
	logic [15:0] d [4];
	bss_supervisor bss_supervisor_inst (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .tick_ms_in(tick), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.move_req_in(mreq), .motor_stopped_in(stopped), .step_in(step),
		.step_dir_in(dir), .enc_a_in(enc_a), .enc_b_in(enc_b),
		.rev_in(rev), .motor_power_out(pwr), .brake_release_out(rel),
		.brake_oe_out(oe), .axis_ready_out(rdy), .move_start_out(mst),
		.alarm_out(alm), .correct_start_out(cst), .irq_out(irq));
	bss_axis_model bss_axis_model_inst (.clk_in(clk_in), .step_in(step),
		.dir_in(dir), .drop_in(drop), .inv_in(inv), .turn_in(turn),
		.enc_a_out(enc_a), .enc_b_out(enc_b), .rev_out(rev),
		.stopped_out(stopped));
	always #5 clk_in = ~clk_in;
	// fast millisecond tick keeps the delays short; pulse tallies; guard
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		tick <= (cyc % 4) == 3;
		if (mst === 1'b1)
			n_st <= n_st + 1;
		if (cst === 1'b1)
			n_co <= n_co + 1;
		if (cyc == 30000)
		begin
			n_fail = n_fail + 1;
			final_report;
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] rst_val(input int i);
		case (i)
			1: return 32'h01f4_012c;
			2: return 32'h0190_012c;
			3: return 32'h0000_c808;
			default: return 32'h0000_0000;
		endcase
	endfunction
	function automatic logic pick(input int s);
		case (s)
			0: return pwr;
			1: return rel;
			default: return rdy;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [31:0] v);
		@(posedge clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a, output logic [31:0] v);
		@(posedge clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic mpulse;
		@(posedge clk_in);
		mreq <= 1'b1;
		@(posedge clk_in);
		mreq <= 1'b0;
	endtask
	task automatic steps(input int k);
		repeat (k)
		begin
			@(posedge clk_in);
			step <= 1'b1;
			@(posedge clk_in);
			step <= 1'b0;
		end
	endtask
	// wait for an output level, counting the ticks taken meanwhile
	task automatic wlvl(input int s, input logic v);
		#1;
		n = 0;
		for (int k = 0; k < 300 && pick(s) !== v; k++)
		begin
			n += tick;
			@(posedge clk_in);
			#1;
		end
		chk(pick(s), v);
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// reset values, unmapped index last
		for (int i = 0; i < 8; i++)
		begin
			rreg(i[2:0], rv);
			chk(rv, rst_val(i));
		end
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			d[i] = {12'h000, seed[3:0] | 4'h1};
		end
		wreg(BSS_REG_DLY_A, {d[1], d[0]});
		wreg(BSS_REG_DLY_B, {d[3], d[2]});
		// command arrives while the brake is still closed
		fork
			wreg(BSS_REG_CTRL, 32'h0000_0103);
			begin
				@(posedge clk_in);
				mpulse;
			end
		join_any
		wlvl(0, 1'b1);
		chk(oe, 1'b1);
		wlvl(1, 1'b1);
		chk(n, d[0]);
		wlvl(2, 1'b1);
		chk(n, d[1]);
		chk(n_st, 0);
		repeat (3) @(posedge clk_in);
		chk(n_st, 1);
		wreg(BSS_REG_CTRL, 32'h0000_0003);
		wlvl(1, 1'b0);
		chk(n >= d[2] && n <= d[2] + 1, 1'b1);
		wlvl(0, 1'b0);
		chk(n, d[3]);
		chk(irq, 1'b0);
		rreg(BSS_REG_STAT, rv);
		chk(rv[3:1], 3'h7);
		// brake control off: straight to ready, brake left alone
		wreg(BSS_REG_CTRL, 32'h0000_0100);
		wlvl(0, 1'b1);
		chk({rdy, oe, rel}, 3'h4);
		t = n_st;
		mpulse;
		repeat (3) @(posedge clk_in);
		chk(n_st, t + 1);
		wreg(BSS_REG_CTRL, 32'h0000_0000);
		wlvl(0, 1'b0);
		// supervision off: steps pile up but raise nothing
		wreg(BSS_REG_MASK, 32'h0000_0001);
		wreg(BSS_REG_SUP, 32'h0000_c800);
		steps(3);
		repeat (4) @(posedge clk_in);
		chk(irq, 1'b0);
		for (int a = 0; a < 4; a++)
		begin
			seed = xs(seed);
			t = seed[2:0];
			dir <= seed[8];
			wreg(BSS_REG_SUP, {8'h00, 16'h00c8, t[7:0]});
			wreg(BSS_REG_CTRL, 32'h204 | (a << 5));
			// stale compare may still set the flag just after the clear
			repeat (3) @(posedge clk_in);
			rreg(BSS_REG_STAT, rv);
			steps(t);
			repeat (4) @(posedge clk_in);
			#1;
			chk({irq, alm}, 2'h0);
			n = n_co;
			steps(1);
			repeat (4) @(posedge clk_in);
			#1;
			chk({irq, alm, n_co != n}, {1'b1, a == 0, a == 1});
			rreg(BSS_REG_STAT, rv);
			chk({rv[0], alm}, 2'h2);
		end
		// encoder follows the steps: counter settles back to zero
		@(posedge clk_in);
		seed = xs(seed);
		inv <= seed[0];
		drop <= 1'b0;
		wreg(BSS_REG_SUP, 32'h0000_c804);
		wreg(BSS_REG_CTRL, 32'h0000_0244 | {27'h0, seed[0], 4'h0});
		repeat (3) @(posedge clk_in);
		rreg(BSS_REG_STAT, rv);
		steps(6);
		repeat (6) @(posedge clk_in);
		rreg(BSS_REG_INFO, rv);
		chk(rv[31:8], 24'h000000);
		rreg(BSS_REG_STAT, rv);
		chk(rv[0], 1'b0);
		// revolution sensor settles a turn on its active edge only
		@(posedge clk_in);
		dir <= 1'b1;
		wreg(BSS_REG_SUP, 32'h0000_0404);
		wreg(BSS_REG_CTRL, 32'h0000_024c | {27'h0, seed[0], 4'h0});
		steps(4);
		@(posedge clk_in);
		turn <= 1'b1;
		repeat (6) @(posedge clk_in);
		rreg(BSS_REG_INFO, rv);
		chk(rv[31:8], 24'h000000);
		@(posedge clk_in);
		turn <= 1'b0;
		repeat (6) @(posedge clk_in);
		rreg(BSS_REG_INFO, rv);
		chk(rv[31:8], 24'h000000);
		final_report;
	end
endmodule
`default_nettype wire
